// File: core/rrts_defs.vh
// Constants for the reset release and test strap block
`ifndef RRTS_DEFS_VH
`define RRTS_DEFS_VH

// ************************************************************
// Clock and timing
// ************************************************************
`define RRTS_CLK_PERIOD_NS 50
`define RRTS_STRAP_DELAY_NS 1500
`define RRTS_STRAP_DELAY_CYC (`RRTS_STRAP_DELAY_NS / `RRTS_CLK_PERIOD_NS)
`define RRTS_CNT_W 5
`define RRTS_CNT_ZERO 5'h00
`define RRTS_CNT_ONE 5'h01

// ************************************************************
// Widths and reset values
// ************************************************************
`define RRTS_PIN_N 8
`define RRTS_PIN_ZERO 8'h00
`define RRTS_PIN_ALL 8'hff

// ************************************************************
// Sequencer states
// ************************************************************
`define RRTS_ST_HELD 2'h0
`define RRTS_ST_SCAN_WAIT 2'h1
`define RRTS_ST_STRAP_WAIT 2'h2
`define RRTS_ST_RUN 2'h3

`endif

// File: core/rrts_sync.v
// Two-stage synchroniser for the power-on reset level
`timescale 1ns/100ps
`include "rrts_defs.vh"

module rrts_sync (
  core_clk,
  sys_rst,
  clk_en,
  async_in,
  sync_out
);
  input wire core_clk;
  input wire sys_rst;
  input wire clk_en;
  input wire async_in;
  output wire sync_out;

  reg meta_reg;
  reg sync_reg;

  // First stage feeds only the second stage
  always @(posedge core_clk) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else if (clk_en) begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule

// File: core/rrts_top.v
// Power-on reset release sequencer with test strap sampling
`timescale 1ns/100ps
`include "rrts_defs.vh"

// Behaviour
// - Reset low active; configure only on rise
// - All outputs inactive while reset held low
// - All eight strap pins tristated during reset
// - Straps sampled about 1.5 us after release
// - Straps become driven outputs after sampling
// - Open pin reads low, selects normal mode

module rrts_top (
  core_clk,
  sys_rst,
  clk_en,
  power_on_reset_low,
  scan_port_reset_low,
  test_strap_pin_i,
  test_strap_pin_o,
  test_strap_pin_oe_n,
  test_obs_data,
  self_config_start,
  self_config_busy,
  device_ready,
  test_mode_sel,
  test_mode_active,
  scan_reset_fault
);
  input wire core_clk;
  input wire sys_rst;
  input wire clk_en;
  input wire power_on_reset_low;
  input wire scan_port_reset_low;
  input wire [`RRTS_PIN_N-1:0] test_strap_pin_i;
  output wire [`RRTS_PIN_N-1:0] test_strap_pin_o;
  output wire [`RRTS_PIN_N-1:0] test_strap_pin_oe_n;
  input wire [`RRTS_PIN_N-1:0] test_obs_data;
  output wire self_config_start;
  output wire self_config_busy;
  output wire device_ready;
  output wire [`RRTS_PIN_N-1:0] test_mode_sel;
  output wire test_mode_active;
  output wire scan_reset_fault;

  // Nominal strap delay in reference clock cycles
  // Integer count cut to the counter width on purpose
  localparam integer STRAP_DELAY_INT = `RRTS_STRAP_DELAY_CYC;
  localparam [`RRTS_CNT_W-1:0] STRAP_DELAY = STRAP_DELAY_INT[`RRTS_CNT_W-1:0];

  // ************************************************************
  // Reset release detection
  // ************************************************************
  wire por_sync;
  reg por_prev_reg;
  wire por_rise;
  wire por_held;

  rrts_sync u_por_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in(power_on_reset_low),
    .sync_out(por_sync)
  );

  always @(posedge core_clk) begin
    if (sys_rst) begin
      por_prev_reg <= 1'b0;
    end else if (clk_en) begin
      por_prev_reg <= por_sync;
    end
  end

  // Only a detected low-to-high edge starts the sequence
  assign por_rise = por_sync & ~por_prev_reg;
  assign por_held = ~por_sync;

  // ************************************************************
  // Sequencer
  // ************************************************************
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [`RRTS_CNT_W-1:0] cnt_reg;
  reg [`RRTS_CNT_W-1:0] cnt_next;
  reg start_reg;
  reg start_next;
  reg fault_reg;
  reg fault_next;
  wire sample_now;

  assign sample_now = (state_reg == `RRTS_ST_STRAP_WAIT) && (cnt_reg == `RRTS_CNT_ONE);

  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    start_next = 1'b0;
    fault_next = fault_reg;
    if (por_held) begin
      // Any return of reset low abandons the sequence
      state_next = `RRTS_ST_HELD;
      cnt_next = `RRTS_CNT_ZERO;
      fault_next = 1'b0;
    end else begin
      case (state_reg)
        `RRTS_ST_HELD: begin
          if (por_rise) begin
            if (scan_port_reset_low) begin
              // Scan reset left high would break start-up; wait
              state_next = `RRTS_ST_SCAN_WAIT;
              fault_next = 1'b1;
            end else begin
              state_next = `RRTS_ST_STRAP_WAIT;
              cnt_next = STRAP_DELAY;
              start_next = 1'b1;
            end
          end
        end
        `RRTS_ST_SCAN_WAIT: begin
          if (!scan_port_reset_low) begin
            state_next = `RRTS_ST_STRAP_WAIT;
            cnt_next = STRAP_DELAY;
            start_next = 1'b1;
            fault_next = 1'b0;
          end
        end
        `RRTS_ST_STRAP_WAIT: begin
          cnt_next = cnt_reg - `RRTS_CNT_ONE;
          if (sample_now) begin
            state_next = `RRTS_ST_RUN;
          end
        end
        `RRTS_ST_RUN: begin
          state_next = `RRTS_ST_RUN;
        end
        default: begin
          state_next = `RRTS_ST_HELD;
          cnt_next = `RRTS_CNT_ZERO;
        end
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= `RRTS_ST_HELD;
      cnt_reg <= `RRTS_CNT_ZERO;
      start_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      start_reg <= start_next;
      fault_reg <= fault_next;
    end
  end

  // ************************************************************
  // Strap capture and pin drive, one slice per pin
  // ************************************************************
  // A high pin needs an external pullup; open pins read low
  reg [`RRTS_PIN_N-1:0] strap_reg;
  reg [`RRTS_PIN_N-1:0] drive_reg;
  reg [`RRTS_PIN_N-1:0] pin_out_reg;
  reg active_reg;

  genvar gi;
  generate
    for (gi = 0; gi < `RRTS_PIN_N; gi = gi + 1) begin : g_pin
      always @(posedge core_clk) begin
        if (sys_rst) begin
          strap_reg[gi] <= 1'b0;
          drive_reg[gi] <= 1'b0;
          pin_out_reg[gi] <= 1'b0;
        end else if (clk_en) begin
          if (por_held) begin
            strap_reg[gi] <= 1'b0;
            drive_reg[gi] <= 1'b0;
            pin_out_reg[gi] <= 1'b0;
          end else if (sample_now) begin
            strap_reg[gi] <= test_strap_pin_i[gi];
            drive_reg[gi] <= 1'b1;
            pin_out_reg[gi] <= 1'b0;
          end else if (drive_reg[gi]) begin
            // Observation data only when a test mode was strapped
            pin_out_reg[gi] <= active_reg & test_obs_data[gi];
          end
        end
      end
    end
  endgenerate

  always @(posedge core_clk) begin
    if (sys_rst) begin
      active_reg <= 1'b0;
    end else if (clk_en) begin
      if (por_held) begin
        active_reg <= 1'b0;
      end else if (sample_now) begin
        active_reg <= |test_strap_pin_i;
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Raw reset gates the enables so pins float with no sync lag
  assign test_strap_pin_oe_n = ~(drive_reg & {`RRTS_PIN_N{power_on_reset_low}});
  assign test_strap_pin_o = pin_out_reg;
  assign test_mode_sel = strap_reg;
  assign test_mode_active = active_reg;
  assign self_config_start = start_reg;
  assign self_config_busy = (state_reg == `RRTS_ST_STRAP_WAIT);
  assign device_ready = (state_reg == `RRTS_ST_RUN);
  assign scan_reset_fault = fault_reg;

endmodule

// File: bench/rrts_pmic_model.sv
// Power manager model driving the power-on and scan resets
`timescale 1ns/100ps
module rrts_pmic_model #(parameter int SETTLE = 4) (
  input wire logic core_clk,
  input wire logic power_good,
  input wire logic scan_hold,
  output logic power_on_reset_low,
  output logic scan_port_reset_low
);
  int cnt;
  initial begin
    cnt = 0;
    power_on_reset_low = 1'b0;
    scan_port_reset_low = 1'b0;
  end
  always @(posedge core_clk) begin
    cnt <= power_good ? (cnt < SETTLE ? cnt + 1 : cnt) : 0;
    // Release only once supplies have settled
    power_on_reset_low <= power_good && cnt == SETTLE;
    scan_port_reset_low <= scan_hold;
  end
endmodule

// File: bench/rrts_top_asserts.sv
// Concurrent checks on the reset release sequencer ports
`timescale 1ns/100ps
module rrts_checker (
  input wire core_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire power_on_reset_low,
  input wire scan_port_reset_low,
  input wire [7:0] test_strap_pin_i,
  input wire [7:0] test_strap_pin_o,
  input wire [7:0] test_strap_pin_oe_n,
  input wire self_config_start,
  input wire self_config_busy,
  input wire device_ready,
  input wire [7:0] test_mode_sel,
  input wire test_mode_active
);
  default clocking cb @(posedge core_clk); endclocking
  // A frozen clock stretches every timed window, so such attempts are dropped
  default disable iff (sys_rst || !clk_en);
  a_start_on_rise:
    assert property ($rose(power_on_reset_low) ##1 power_on_reset_low ##1
      (power_on_reset_low && !scan_port_reset_low) |=> self_config_start) else $error("no start");
  a_held_quiet:
    assert property (!power_on_reset_low [*3] |=> !self_config_start && !self_config_busy && !device_ready
      && !test_mode_active && test_strap_pin_o == 8'h00) else $error("active in reset");
  a_pins_float:
    assert property (!power_on_reset_low |-> test_strap_pin_oe_n == 8'hff) else $error("pins driven");
  a_strap_time:
    assert property (disable iff (sys_rst || !clk_en || !power_on_reset_low) self_config_start |-> ##29 !device_ready
      ##1 device_ready && test_mode_sel == $past(test_strap_pin_i)) else $error("strap timing");
  a_pins_driven:
    assert property (device_ready && power_on_reset_low |-> test_strap_pin_oe_n == 8'h00) else $error("float");
  a_mode_select:
    assert property (device_ready |-> test_mode_active == (|test_mode_sel)) else $error("mode");
  a_sync_delay:
    assert property ($rose(power_on_reset_low) |-> !self_config_start [*3]) else $error("early start");
  a_busy_hold:
    assert property (disable iff (sys_rst || !clk_en || !power_on_reset_low)
      self_config_start |=> self_config_busy [*8]) else $error("busy");
  c_start: cover property (self_config_start);
  c_test: cover property (device_ready && test_mode_active);
  c_abort: cover property (self_config_busy ##1 !power_on_reset_low);
endmodule
bind rrts_top rrts_checker u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .power_on_reset_low(power_on_reset_low), .scan_port_reset_low(scan_port_reset_low),
  .test_strap_pin_i(test_strap_pin_i), .test_strap_pin_o(test_strap_pin_o),
  .test_strap_pin_oe_n(test_strap_pin_oe_n), .self_config_start(self_config_start),
  .self_config_busy(self_config_busy), .device_ready(device_ready), .test_mode_sel(test_mode_sel),
  .test_mode_active(test_mode_active));

// File: bench/tb_reset_release_test_strap.sv
// Testbench for the reset release sequencer
`timescale 1ns/100ps
module tb_reset_release_test_strap;
  logic core_clk = 1'b0, sys_rst = 1'b1, power_good = 1'b0, scan_hold = 1'b0, clk_en = 1'b1;
  logic [7:0] pull = 8'h00, obs = 8'h3c;
  wire por_n, scan_n, start, busy, ready, act, fault;
  wire [7:0] pin_o, oe_n, sel;
  wire [7:0] pins = (~oe_n & pin_o) | (oe_n & pull); // Weak pulldown: open pin reads low
  int fail_count = 0, num_checks = 0, cyc = 0, n;
  always #25 core_clk = ~core_clk;
  rrts_pmic_model PMIC (.core_clk(core_clk), .power_good(power_good), .scan_hold(scan_hold),
    .power_on_reset_low(por_n), .scan_port_reset_low(scan_n));
  rrts_top DUT (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .power_on_reset_low(por_n),
    .scan_port_reset_low(scan_n), .test_strap_pin_i(pins), .test_strap_pin_o(pin_o),
    .test_strap_pin_oe_n(oe_n), .test_obs_data(obs), .self_config_start(start), .self_config_busy(busy),
    .device_ready(ready), .test_mode_sel(sel), .test_mode_active(act), .scan_reset_fault(fault));
  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      close_out;
    end
  end
  task tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // ****************
  // Scenarios
  // ****************
  task t_rise;
    @(posedge core_clk) power_good <= 1'b1;
    for (n = 0; n < 40 && start !== 1'b1; n++) tick(1);
    chk("start", start, 1);
  endtask
  task t_drop;
    @(posedge core_clk) power_good <= 1'b0;
    tick(1);
    chk("oe_n", oe_n, 8'hff);
    tick(4);
    chk("idle", {ready, busy, act, start, fault, 3'h0}, 0);
    chk("pin_o", pin_o, 0);
  endtask
  task t_boot(input logic [7:0] p);
    @(posedge core_clk) pull <= p;
    t_rise;
    for (n = 0; n < 40 && ready !== 1'b1; n++) tick(1);
    chk("delay", n[7:0], 8'h1e);
    chk("sel", sel, p);
    chk("active", act, |p);
    chk("oe_n", oe_n, 0);
    tick(2);
    chk("pin_o", pin_o, (|p) ? obs : 8'h00);
    t_drop;
  endtask
  task t_abort;
    @(posedge core_clk) pull <= 8'h0f;
    t_rise;
    tick(10);
    t_drop;
    tick(40);
    chk("no restart", {ready, start}, 0);
    // A fresh rise after the abort must run the full strap delay again
    t_boot(8'h0f);
  endtask
  task t_freeze;
    t_rise;
    tick(10);
    @(posedge core_clk) clk_en <= 1'b0;
    tick(20);
    chk("frozen", {busy, ready, start}, 8'h04);
    @(posedge core_clk) clk_en <= 1'b1;
    #1;
    for (n = 0; n < 40 && ready !== 1'b1; n++) tick(1);
    chk("frozen delay", n[7:0], 8'h13);
    t_drop;
  endtask
  task t_scan;
    @(posedge core_clk) scan_hold <= 1'b1;
    tick(2);
    @(posedge core_clk) begin
      pull <= 8'h00;
      power_good <= 1'b1;
    end
    tick(15);
    chk("stall", {fault, start, busy}, 8'h04);
    @(posedge core_clk) scan_hold <= 1'b0;
    for (n = 0; n < 10 && start !== 1'b1; n++) tick(1);
    chk("late start", {start, fault}, 8'h02);
    t_drop;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_boot(8'h00);
    t_boot(8'ha5);
    t_boot(8'h80);
    t_abort;
    t_scan;
    t_freeze;
    close_out;
  end
endmodule
